// >>> ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "lane_write_defs.svh"

module ctrl_model (
   input  wire logic                   mclk_i,
   output logic                        wps_n_o,
   output logic                        valid_o,
   output logic [`ADDR_WIDTH-1:0]      addr_o,
   output logic [`WORD_WIDTH-1:0]      data_o,
   output logic [`LANE_COUNT-1:0]      sel_n_o
);
   initial begin
      wps_n_o = 1'b1;
      valid_o = 1'b0;
      addr_o  = 4'h0;
      data_o  = 36'h0_0000_0000;
      sel_n_o = 4'hF;
   end

   // Called at a falling edge; holds the beat across one rising edge
   task automatic send(input logic [3:0] a, input logic [35:0] d,
                       input logic [3:0] s, input logic w);
      wps_n_o = w;
      valid_o = 1'b1;
      addr_o  = a;
      data_o  = d;
      sel_n_o = s;
      @(negedge mclk_i);
   endtask : send

   // Released lines flip so a stale beat can never look valid
   task automatic idle();
      wps_n_o = 1'b1;
      valid_o = 1'b0;
      addr_o  = ~addr_o;
      data_o  = ~data_o;
      sel_n_o = 4'hF;
      @(negedge mclk_i);
   endtask : idle
endmodule : ctrl_model
`default_nettype wire

// >>> lane_merge.sv
`timescale 1ns/10ps
`default_nettype none
`include "lane_write_defs.svh"

module lane_merge (
   input  wire logic                   lane_we_i,
   input  wire logic [`LANE_WIDTH-1:0] old_bits_i,
   input  wire logic [`LANE_WIDTH-1:0] new_bits_i,
   output logic      [`LANE_WIDTH-1:0] merged_o
);
   always_comb begin
      merged_o = lane_we_i ? new_bits_i : old_bits_i;
   end
endmodule : lane_merge

`default_nettype wire

// >>> lane_write_defs.svh
`ifndef LANE_WRITE_DEFS_SVH
`define LANE_WRITE_DEFS_SVH

`define LANE_WIDTH     9
`define LANE_COUNT     4
`define WORD_WIDTH     36
`define ADDR_WIDTH     4
`define WORD_DEPTH     16
`define LANE_SEL_IDLE  4'h0_00F

`endif

// >>> lane_write_pkg.sv
`default_nettype none

package lane_write_pkg;
   typedef enum logic {
      cfg_four_lane,
      cfg_single_lane
   } lane_cfg_t;

   typedef enum logic {
      beat_first,
      beat_second
   } beat_phase_t;
endpackage : lane_write_pkg

`default_nettype wire

// >>> sram_byte_write_lanes.sv
// Contract
// - Each beat uses the lane selects sampled with that same beat.
// - Four-lane, only select one low: write bits 17:9 only.
// - Four-lane, only select two low: write bits 26:18 only.
// - Four-lane, only select three low: write bits 35:27 only.
// - Four-lane, all selects high: nothing written that beat.
// - Single-lane, select low: write bits 8:0 of the beat.
// - Single-lane, select high: word unchanged for that beat.
// - Four-lane, only select zero low: write bits 8:0 only.
// - Four-lane, all four selects low: whole 36-bit beat stored.
`timescale 1ns/10ps
`default_nettype none
`include "lane_write_defs.svh"

module sram_byte_write_lanes (
   input  wire logic                    mclk_i,
   input  wire logic                    rst_b_i,
   input  wire logic                    single_lane_cfg_i,
   input  wire logic                    write_port_sel_n_i,
   input  wire logic                    beat_valid_i,
   input  wire logic [`ADDR_WIDTH-1:0]  write_addr_i,
   input  wire logic [`WORD_WIDTH-1:0]  write_data_i,
   input  wire logic                    lane0_write_select_n_i,
   input  wire logic                    lane1_write_select_n_i,
   input  wire logic                    lane2_write_select_n_i,
   input  wire logic                    lane3_write_select_n_i,
   input  wire logic [`ADDR_WIDTH-1:0]  read_addr_i,
   output logic      [`WORD_WIDTH-1:0]  read_data_o,
   output logic      [`LANE_COUNT-1:0]  lanes_written_o,
   output logic                         beat_phase_o
);
   // Array has no reset: contents are undefined until written
   logic [`WORD_WIDTH-1:0] mem_reg [`WORD_DEPTH];

   logic [`LANE_COUNT-1:0] sel_n;
   logic [`LANE_COUNT-1:0] lane_we;
   logic [`WORD_WIDTH-1:0] old_word;
   logic [`WORD_WIDTH-1:0] merged_word;
   logic                   in_write;
   logic [`WORD_WIDTH-1:0] read_data_reg;
   logic [`WORD_WIDTH-1:0] read_data_next;
   logic [`LANE_COUNT-1:0] lanes_written_reg;
   logic [`LANE_COUNT-1:0] lanes_written_next;
   lane_write_pkg::beat_phase_t phase_reg;
   lane_write_pkg::beat_phase_t phase_next;
   lane_write_pkg::lane_cfg_t   cfg;

   assign cfg = single_lane_cfg_i ? lane_write_pkg::cfg_single_lane
                                  : lane_write_pkg::cfg_four_lane;
   assign sel_n = {lane3_write_select_n_i, lane2_write_select_n_i,
                   lane1_write_select_n_i, lane0_write_select_n_i};
   assign in_write = beat_valid_i && !write_port_sel_n_i;
   assign old_word = mem_reg[write_addr_i];

   // Lane enables decoded per beat from this beat's selects
   always_comb begin
      lane_we = '0;
      if (in_write) begin
         case (cfg)
            lane_write_pkg::cfg_single_lane: begin
               lane_we[0] = !sel_n[0];
            end
            lane_write_pkg::cfg_four_lane: begin
               lane_we = ~sel_n;
            end
            default: begin
               lane_we = '0;
            end
         endcase
      end
   end

   genvar g;
   generate
      for (g = 0; g < `LANE_COUNT; g++) begin : g_lane
         lane_merge u_merge (
            .lane_we_i  (lane_we[g]),
            .old_bits_i (old_word[g*`LANE_WIDTH +: `LANE_WIDTH]),
            .new_bits_i (write_data_i[g*`LANE_WIDTH +: `LANE_WIDTH]),
            .merged_o   (merged_word[g*`LANE_WIDTH +: `LANE_WIDTH])
         );
      end
   endgenerate

   always_ff @(posedge mclk_i) begin
      if (|lane_we) begin
         mem_reg[write_addr_i] <= merged_word;
      end
   end

   // Second beat of a burst follows the first; a gap restarts the pair
   always_comb begin
      read_data_next     = mem_reg[read_addr_i];
      lanes_written_next = lane_we;
      phase_next         = phase_reg;
      if (in_write) begin
         case (phase_reg)
            lane_write_pkg::beat_first: begin
               phase_next = lane_write_pkg::beat_second;
            end
            lane_write_pkg::beat_second: begin
               phase_next = lane_write_pkg::beat_first;
            end
            default: begin
               phase_next = lane_write_pkg::beat_first;
            end
         endcase
      end else begin
         phase_next = lane_write_pkg::beat_first;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         read_data_reg     <= '0;
         lanes_written_reg <= '0;
         phase_reg         <= lane_write_pkg::beat_first;
      end else begin
         read_data_reg     <= read_data_next;
         lanes_written_reg <= lanes_written_next;
         phase_reg         <= phase_next;
      end
   end

   assign read_data_o     = read_data_reg;
   assign lanes_written_o = lanes_written_reg;
   assign beat_phase_o    = (phase_reg == lane_write_pkg::beat_second);

   property p_lane1_only;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (in_write && !single_lane_cfg_i && sel_n == 4'h0_00D)
      |-> merged_word == {old_word[35:18], write_data_i[17:9],
                          old_word[8:0]};
   endproperty
   a_lane1_only: assert property (p_lane1_only)
      else $error("Lane one write touched other lanes");

   property p_lane2_only;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (in_write && !single_lane_cfg_i && sel_n == 4'h0_00B)
      |-> merged_word == {old_word[35:27], write_data_i[26:18],
                          old_word[17:0]};
   endproperty
   a_lane2_only: assert property (p_lane2_only)
      else $error("Lane two write touched other lanes");

   property p_lane3_only;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (in_write && !single_lane_cfg_i && sel_n == 4'h0_007)
      |-> merged_word == {write_data_i[35:27], old_word[26:0]};
   endproperty
   a_lane3_only: assert property (p_lane3_only)
      else $error("Lane three write touched other lanes");

   property p_lane0_only;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (in_write && !single_lane_cfg_i && sel_n == 4'h0_00E)
      |-> merged_word == {old_word[35:9], write_data_i[8:0]};
   endproperty
   a_lane0_only: assert property (p_lane0_only)
      else $error("Lane zero write touched other lanes");

   property p_all_high;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (sel_n == `LANE_SEL_IDLE) |=> lanes_written_o == 4'h0_000;
   endproperty
   a_all_high: assert property (p_all_high)
      else $error("Write occurred with all selects high");

   property p_all_low;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (in_write && !single_lane_cfg_i && sel_n == 4'h0_000)
      |=> mem_reg[$past(write_addr_i)] == $past(write_data_i);
   endproperty
   a_all_low: assert property (p_all_low)
      else $error("Full word write not stored");

   property p_single_low;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (in_write && single_lane_cfg_i && !sel_n[0])
      |=> lanes_written_o == 4'h0_001;
   endproperty
   a_single_low: assert property (p_single_low)
      else $error("Single lane write not enabled");

   property p_single_high;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (single_lane_cfg_i && sel_n[0]) |-> lane_we == 4'h0_000;
   endproperty
   a_single_high: assert property (p_single_high)
      else $error("Single lane high select still wrote");

   property p_mixed;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (in_write && !single_lane_cfg_i) |=> lanes_written_o == ~$past(sel_n);
   endproperty
   a_mixed: assert property (p_mixed)
      else $error("Lane enables differ from low selects");

   property p_per_beat;
      @(posedge mclk_i) disable iff (!rst_b_i)
      (in_write && !single_lane_cfg_i) ##1 (in_write && !single_lane_cfg_i)
      |-> lane_we == ~sel_n;
   endproperty
   a_per_beat: assert property (p_per_beat)
      else $error("Second beat used stale selects");

   property p_no_write_cycle;
      @(posedge mclk_i) disable iff (!rst_b_i)
      write_port_sel_n_i |=> lanes_written_o == 4'h0_000;
   endproperty
   a_no_write_cycle: assert property (p_no_write_cycle)
      else $error("Write outside a write cycle");
endmodule : sram_byte_write_lanes

`default_nettype wire

// >>> tb_sram_byte_write_lanes.sv
`timescale 1ns/10ps
`default_nettype none
`include "lane_write_defs.svh"

module tb_sram_byte_write_lanes;
   logic        mclk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        cfg = 1'b0;
   logic [3:0]  raddr = 4'h0;
   logic [3:0]  waddr, sel_n, lanes, exp_lanes;
   logic [35:0] wdata, rdata;
   logic        wps_n, valid, phase;
   logic [35:0] ref_mem [16];
   int          n_fail = 0;
   int          tests_run = 0;

   always #2 mclk_i = ~mclk_i;

   ctrl_model ctrl_model_inst (.mclk_i(mclk_i), .wps_n_o(wps_n),
      .valid_o(valid), .addr_o(waddr), .data_o(wdata), .sel_n_o(sel_n));

   sram_byte_write_lanes sram_byte_write_lanes_inst (.mclk_i(mclk_i),
      .rst_b_i(rst_b_i), .single_lane_cfg_i(cfg),
      .write_port_sel_n_i(wps_n), .beat_valid_i(valid),
      .write_addr_i(waddr), .write_data_i(wdata),
      .lane0_write_select_n_i(sel_n[0]), .lane1_write_select_n_i(sel_n[1]),
      .lane2_write_select_n_i(sel_n[2]), .lane3_write_select_n_i(sel_n[3]),
      .read_addr_i(raddr), .read_data_o(rdata), .lanes_written_o(lanes),
      .beat_phase_o(phase));

   task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_lanes(input logic [3:0] got, input logic [3:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_lanes

   // Shadow copy follows the lanes that ought to be written
   task automatic beat(input logic [3:0] a, input logic [35:0] d,
                       input logic [3:0] s, input logic w);
      exp_lanes = 4'h0;
      for (int i = 0; i < 4; i++)
         if (!w && !s[i] && (!cfg || i == 0)) begin
            exp_lanes[i] = 1'b1;
            ref_mem[a][i*9 +: 9] = d[i*9 +: 9];
         end
      ctrl_model_inst.send(a, d, s, w);
   endtask : beat

   // Lane enables stand for one cycle only: judge them before idling
   task automatic settle(input logic [3:0] a);
      chk_lanes(lanes, exp_lanes);
      raddr = a;
      ctrl_model_inst.idle();
      chk_word(rdata, ref_mem[a]);
   endtask : settle

   task automatic t_full();
      for (int a = 0; a < 4; a++) begin
         beat(a[3:0], 36'h1_2345_6789 * (a + 1), 4'h0, 1'b0);
         settle(a[3:0]);
      end
      $display("test full done");
   endtask : t_full

   task automatic t_lanes();
      logic [3:0] pat [6];
      pat = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hF, 4'h5};
      for (int i = 0; i < 6; i++) begin
         beat(i[1:0], 36'hA_5C3C_96F0 ^ i, pat[i], 1'b0);
         settle(i[1:0]);
      end
      $display("test lanes done");
   endtask : t_lanes

   task automatic t_burst();
      beat(4'h2, 36'h0_1234_5678, 4'hE, 1'b0);
      chk_lanes({3'b000, phase}, 4'h1);
      beat(4'h2, 36'hF_EDCB_A987, 4'h7, 1'b0);
      chk_lanes({3'b000, phase}, 4'h0);
      settle(4'h2);
      beat(4'h3, 36'h3_3333_3333, 4'h0, 1'b1);
      settle(4'h3);
      $display("test burst done");
   endtask : t_burst

   task automatic t_single();
      cfg = 1'b1;
      beat(4'h1, 36'hC_CCCC_C1A5, 4'hE, 1'b0);
      settle(4'h1);
      beat(4'h1, 36'h5_5555_5E5A, 4'h1, 1'b0);
      settle(4'h1);
      $display("test single done");
   endtask : t_single

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   initial begin
      repeat (12) @(negedge mclk_i);
      rst_b_i = 1'b1;
      t_full();
      t_lanes();
      t_burst();
      t_single();
      conclude();
   end

   // Run needs well under 100 cycles; this bound is generous
   initial begin
      #20000;
      n_fail++;
      conclude();
   end
endmodule : tb_sram_byte_write_lanes
`default_nettype wire
